// file: design/rcg_pkg.sv
// package for the run-mode clock gating block: register map, field
// positions, reset values, power modes and sample-rate timing.
// assumes a 25 MHz core clock and a 32-bit classic wishbone register bus.
package rcg_pkg;

	// bus geometry
	localparam int RCG_DW = 32;
	localparam int RCG_AW = 12;
	localparam int RCG_SELW = 4;

	// register byte offsets
	localparam logic [11:0] RCG_OFS_CAP = 12'h010;
	localparam logic [11:0] RCG_OFS_CFG = 12'h060;
	localparam logic [11:0] RCG_OFS_RUN = 12'h100;
	localparam logic [11:0] RCG_OFS_SLP = 12'h110;
	localparam logic [11:0] RCG_OFS_DSLP = 12'h120;
	localparam logic [11:0] RCG_OFS_EFF = 12'h130;
	localparam logic [11:0] RCG_OFS_FLT = 12'h134;

	// reset values and writable masks
	localparam logic [31:0] RCG_GATE_RST = 32'h00000040;
	localparam logic [31:0] RCG_GATE_WMASK = 32'h00110308;
	localparam logic [31:0] RCG_GATE_ROMASK = 32'h00000040;
	localparam logic [31:0] RCG_CAP_VAL = 32'h00000003;
	localparam logic [31:0] RCG_CFG_RST = 32'h00000000;
	localparam logic [31:0] RCG_CFG_WMASK = 32'h00000001;
	localparam logic [31:0] RCG_ZERO = 32'h00000000;

	// field positions
	localparam int RCG_BIT_PWM = 20;
	localparam int RCG_BIT_ADC = 16;
	localparam int RCG_BIT_WDT = 3;
	localparam int RCG_SPD_LO = 8;
	localparam int RCG_SPD_HI = 9;
	localparam int RCG_BIT_ACG = 0;
	localparam int RCG_BIT_PORTA = 0;
	localparam int RCG_BIT_PORTB = 1;

	// gated units, one index each
	localparam int RCG_NUM_UNITS = 3;
	localparam int RCG_U_WDT = 0;
	localparam int RCG_U_ADC = 1;
	localparam int RCG_U_PWM = 2;

	// sample-rate codes
	localparam logic [1:0] RCG_SPD_125K = 2'h0;
	localparam logic [1:0] RCG_SPD_250K = 2'h1;

	// timing
	localparam int RCG_CLK_NS = 40;
	localparam int RCG_T125K_NS = 8000;
	localparam int RCG_T250K_NS = 4000;
	localparam int RCG_CYC_125K = RCG_T125K_NS / RCG_CLK_NS;
	localparam int RCG_CYC_250K = RCG_T250K_NS / RCG_CLK_NS;
	localparam int RCG_DIV_W = 8;

	// system power mode, one-hot
	typedef enum logic [2:0] {
		RCG_MODE_RUN = 3'b001,
		RCG_MODE_SLEEP = 3'b010,
		RCG_MODE_DEEP = 3'b100
	} rcg_mode_e;

endpackage : rcg_pkg

// file: design/rcg_unit_gate.sv
// one gated unit: registered clock enable, disable hold and access fault.
// assumes unit accesses are one-cycle pulses on the core clock.
`timescale 1ns/1ps
`default_nettype none
module rcg_unit_gate (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic gate_on,
	input wire logic access,
	output var logic clk_en,
	output var logic hold,
	output var logic fault
);

	// enable is a flop so the unit clock only changes on an edge
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			clk_en <= 1'b0;
			hold <= 1'b1;
		end else begin
			clk_en <= gate_on;
			hold <= ~gate_on;
		end
	end

	// access to an unclocked unit answers with a fault
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			fault <= 1'b0;
		end else begin
			fault <= access & ~clk_en;
		end
	end

endmodule : rcg_unit_gate
`default_nettype wire

// file: design/rcg_top.sv
// run-mode clock gating control with sleep and deep-sleep gating,
// capability bits, access fault reporting and converter sample pacing.
// assumes a 25 MHz core clock, a classic wishbone master and power-mode
// requests and unit accesses generated on the same clock.
// Operation
// - a set gating bit clocks its unit; a clear bit stops and holds it
// - access to an unclocked unit returns a bus fault
// - gating bits reset to zero; register resets to 0x00000040
// - the run gating register governs clocks during run operation
// - sleep and deep-sleep registers apply only with auto gating set
// - bit 20 gates the pwm unit clock, resets to zero
// - bit 16 gates converter module 0 clock, resets to zero
// - bit 3 gates the watchdog clock, resets to zero
// - bits 9:8 pick sample rate: 1 is 250K, 0 is 125K
// - reserved bits read zero except bit 6, which reads one; software preserves them on writes
// - capability bits 1 and 0 read one: ports b and a present
`timescale 1ns/1ps
`default_nettype none
module rcg_top
	import rcg_pkg::*;
#(
	parameter int NUM_UNITS = RCG_NUM_UNITS
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [RCG_AW-1:0] wb_adr_i,
	input wire logic [RCG_SELW-1:0] wb_sel_i,
	input wire logic [RCG_DW-1:0] wb_dat_i,
	output var logic [RCG_DW-1:0] wb_dat_o,
	output var logic wb_ack_o,
	output var logic wb_err_o,
	input wire logic sleep_req,
	input wire logic deep_sleep_req,
	input wire logic [NUM_UNITS-1:0] unit_access,
	output var logic [NUM_UNITS-1:0] unit_clk_en,
	output var logic [NUM_UNITS-1:0] unit_hold,
	output var logic [NUM_UNITS-1:0] unit_fault,
	output var logic [1:0] converter_sample_rate,
	output var logic adc_sample_tick,
	output var logic [2:0] power_mode
);

	// register bit that gates each unit
	function automatic int unit_bit(input int u);
		case (u)
			RCG_U_WDT: unit_bit = RCG_BIT_WDT;
			RCG_U_ADC: unit_bit = RCG_BIT_ADC;
			default: unit_bit = RCG_BIT_PWM;
		endcase
	endfunction : unit_bit

	// gather unit enables out of a gating register image
	function automatic logic [NUM_UNITS-1:0] unit_bits(
		input logic [RCG_DW-1:0] img
	);
		logic [NUM_UNITS-1:0] v;
		v = '0;
		for (int u = 0; u < NUM_UNITS; u++) begin
			v[u] = img[unit_bit(u)];
		end
		unit_bits = v;
	endfunction : unit_bits

	// merge byte-enabled write data into an image, writable bits only
	function automatic logic [RCG_DW-1:0] merge(
		input logic [RCG_DW-1:0] old,
		input logic [RCG_DW-1:0] wdat,
		input logic [RCG_SELW-1:0] sel,
		input logic [RCG_DW-1:0] wmask
	);
		logic [RCG_DW-1:0] m;
		m = '0;
		for (int b = 0; b < RCG_SELW; b++) begin
			m[b*8 +: 8] = {8{sel[b]}};
		end
		m = m & wmask;
		merge = (old & ~m) | (wdat & m);
	endfunction : merge

	// gating register write: only documented fields change
	function automatic logic [RCG_DW-1:0] gate_write(
		input logic [RCG_DW-1:0] old,
		input logic [RCG_DW-1:0] wdat,
		input logic [RCG_SELW-1:0] sel
	);
		gate_write = merge(old, wdat, sel, RCG_GATE_WMASK)
			| RCG_GATE_ROMASK;
	endfunction : gate_write

	// ------------------------------------------------------------ bus
	logic req;
	logic wr;
	logic hit_cap;
	logic hit_cfg;
	logic hit_run;
	logic hit_slp;
	logic hit_dslp;
	logic hit_eff;
	logic hit_flt;
	logic mapped;

	logic [RCG_DW-1:0] run_clock_gate_ctrl0;
	logic [RCG_DW-1:0] sleep_clock_gate_ctrl0;
	logic [RCG_DW-1:0] deep_sleep_clock_gate_ctrl0;
	logic [RCG_DW-1:0] run_clock_config;
	logic [NUM_UNITS-1:0] fault_sticky;
	logic [NUM_UNITS-1:0] gate_eff;
	logic [NUM_UNITS-1:0] fault_pulse;
	logic [RCG_DW-1:0] rd_mux;
	logic auto_gating_select;

	// a request is taken once; the cycle that shows the answer is idle
	assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
	assign wr = req & wb_we_i;

	assign hit_cap = (wb_adr_i == RCG_OFS_CAP);
	assign hit_cfg = (wb_adr_i == RCG_OFS_CFG);
	assign hit_run = (wb_adr_i == RCG_OFS_RUN);
	assign hit_slp = (wb_adr_i == RCG_OFS_SLP);
	assign hit_dslp = (wb_adr_i == RCG_OFS_DSLP);
	assign hit_eff = (wb_adr_i == RCG_OFS_EFF);
	assign hit_flt = (wb_adr_i == RCG_OFS_FLT);
	assign mapped = hit_cap | hit_cfg | hit_run | hit_slp | hit_dslp
		| hit_eff | hit_flt;

	assign auto_gating_select = run_clock_config[RCG_BIT_ACG];

	// read data; reserved bits come back as zero, except gating register bit 6 as one
	always_comb begin
		rd_mux = RCG_ZERO;
		if (hit_cap) begin
			rd_mux = RCG_CAP_VAL;
		end else if (hit_cfg) begin
			rd_mux = run_clock_config;
		end else if (hit_run) begin
			rd_mux = run_clock_gate_ctrl0;
		end else if (hit_slp) begin
			rd_mux = sleep_clock_gate_ctrl0;
		end else if (hit_dslp) begin
			rd_mux = deep_sleep_clock_gate_ctrl0;
		end else if (hit_eff) begin
			for (int u = 0; u < NUM_UNITS; u++) begin
				rd_mux[unit_bit(u)] = gate_eff[u];
			end
		end else if (hit_flt) begin
			rd_mux[NUM_UNITS-1:0] = fault_sticky;
		end
	end

	// registered answer: ack for mapped offsets, err for the rest
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			wb_ack_o <= 1'b0;
			wb_err_o <= 1'b0;
			wb_dat_o <= RCG_ZERO;
		end else begin
			wb_ack_o <= req & mapped;
			wb_err_o <= req & ~mapped;
			if (req & mapped & ~wb_we_i) begin
				wb_dat_o <= rd_mux;
			end
		end
	end

	// ------------------------------------------------------ registers
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			run_clock_gate_ctrl0 <= RCG_GATE_RST;
		end else if (wr & hit_run) begin
			run_clock_gate_ctrl0 <= gate_write(run_clock_gate_ctrl0,
				wb_dat_i, wb_sel_i);
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			sleep_clock_gate_ctrl0 <= RCG_GATE_RST;
		end else if (wr & hit_slp) begin
			sleep_clock_gate_ctrl0 <= gate_write(sleep_clock_gate_ctrl0,
				wb_dat_i, wb_sel_i);
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			deep_sleep_clock_gate_ctrl0 <= RCG_GATE_RST;
		end else if (wr & hit_dslp) begin
			deep_sleep_clock_gate_ctrl0 <= gate_write(
				deep_sleep_clock_gate_ctrl0, wb_dat_i, wb_sel_i);
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			run_clock_config <= RCG_CFG_RST;
		end else if (wr & hit_cfg) begin
			run_clock_config <= merge(run_clock_config, wb_dat_i,
				wb_sel_i, RCG_CFG_WMASK);
		end
	end

	// fault record: a new fault wins over a write-one clear
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			fault_sticky <= '0;
		end else begin
			if (wr & hit_flt & wb_sel_i[0]) begin
				fault_sticky <= (fault_sticky
					& ~wb_dat_i[NUM_UNITS-1:0]) | fault_pulse;
			end else begin
				fault_sticky <= fault_sticky | fault_pulse;
			end
		end
	end

	// ----------------------------------------------------- power mode
	rcg_mode_e mode;
	rcg_mode_e next_mode;

	always_comb begin
		next_mode = mode;
		case (mode)
			RCG_MODE_RUN: begin
				if (deep_sleep_req) begin
					next_mode = RCG_MODE_DEEP;
				end else if (sleep_req) begin
					next_mode = RCG_MODE_SLEEP;
				end
			end
			RCG_MODE_SLEEP: begin
				if (deep_sleep_req) begin
					next_mode = RCG_MODE_DEEP;
				end else if (!sleep_req) begin
					next_mode = RCG_MODE_RUN;
				end
			end
			RCG_MODE_DEEP: begin
				if (!deep_sleep_req) begin
					next_mode = sleep_req ? RCG_MODE_SLEEP : RCG_MODE_RUN;
				end
			end
			default: next_mode = RCG_MODE_RUN;
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			mode <= RCG_MODE_RUN;
		end else begin
			mode <= next_mode;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			power_mode <= RCG_MODE_RUN;
		end else begin
			power_mode <= next_mode;
		end
	end

	// ------------------------------------------------ gating select
	// without auto gating the run settings hold in every mode
	always_comb begin
		gate_eff = unit_bits(run_clock_gate_ctrl0);
		if (auto_gating_select && mode == RCG_MODE_SLEEP) begin
			gate_eff = unit_bits(sleep_clock_gate_ctrl0);
		end else if (auto_gating_select && mode == RCG_MODE_DEEP) begin
			gate_eff = unit_bits(deep_sleep_clock_gate_ctrl0);
		end
	end

	genvar gu;
	generate
		for (gu = 0; gu < NUM_UNITS; gu++) begin : g_unit
			rcg_unit_gate u_gate (
				.core_clk(core_clk),
				.rst_n(rst_n),
				.gate_on(gate_eff[gu]),
				.access(unit_access[gu]),
				.clk_en(unit_clk_en[gu]),
				.hold(unit_hold[gu]),
				.fault(fault_pulse[gu])
			);
		end
	endgenerate

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			unit_fault <= '0;
		end else begin
			unit_fault <= fault_pulse;
		end
	end

	// --------------------------------------------- converter pacing
	logic [RCG_DIV_W-1:0] div_cnt;
	logic [RCG_DIV_W-1:0] div_period;
	logic [1:0] spd;

	assign spd = run_clock_gate_ctrl0[RCG_SPD_HI:RCG_SPD_LO];

	// codes above the fastest documented one are paced at the fastest
	always_comb begin
		if (spd == RCG_SPD_125K) begin
			div_period = RCG_DIV_W'(RCG_CYC_125K - 1);
		end else begin
			div_period = RCG_DIV_W'(RCG_CYC_250K - 1);
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			converter_sample_rate <= RCG_SPD_125K;
		end else begin
			converter_sample_rate <= spd;
		end
	end

	// ticks stop while the converter clock is off
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			div_cnt <= '0;
			adc_sample_tick <= 1'b0;
		end else if (!unit_clk_en[RCG_U_ADC]) begin
			div_cnt <= '0;
			adc_sample_tick <= 1'b0;
		end else if (div_cnt >= div_period) begin
			div_cnt <= '0;
			adc_sample_tick <= 1'b1;
		end else begin
			div_cnt <= div_cnt + 1'b1;
			adc_sample_tick <= 1'b0;
		end
	end

endmodule : rcg_top
`default_nettype wire

// file: sim/rcg_top_props.sv
// port assertions for the run-mode clock gating block
// assumes one clock domain and binding onto rcg_top
`timescale 1ns/1ps
`default_nettype none
module rcg_top_props
	import rcg_pkg::*;
#(
	parameter int NUM_UNITS = RCG_NUM_UNITS
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	input wire logic wb_err_o,
	input wire logic sleep_req,
	input wire logic deep_sleep_req,
	input wire logic [NUM_UNITS-1:0] unit_access,
	input wire logic [NUM_UNITS-1:0] unit_clk_en,
	input wire logic [NUM_UNITS-1:0] unit_hold,
	input wire logic [NUM_UNITS-1:0] unit_fault,
	input wire logic adc_sample_tick,
	input wire logic [2:0] power_mode
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	sequence s_req;
		wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
	endsequence
	sequence s_dead_poke;
		unit_access[RCG_U_ADC] && !unit_clk_en[RCG_U_ADC];
	endsequence
	a_bus_answer: assert property (s_req |=> wb_ack_o || wb_err_o)
		else $error("request not answered in one cycle");
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	a_fault_on_gated: assert property (s_dead_poke |-> ##2 unit_fault[1])
		else $error("gated access gave no fault");
	a_fault_cause: assert property (unit_fault[1] |->
		$past(unit_access[1], 2) && !$past(unit_clk_en[1], 2))
		else $error("fault without gated access");
	a_hold_inverse: assert property (unit_hold == ~unit_clk_en)
		else $error("hold not inverse of clock enable");
	a_reset_off: assert property ($rose(rst_n) |-> unit_clk_en == '0)
		else $error("unit clocked right after reset");
	a_deep_mode: assert property (deep_sleep_req |=> power_mode == 3'h4)
		else $error("deep sleep not reported");
	a_run_mode: assert property (!sleep_req && !deep_sleep_req
		|=> power_mode == 3'h1)
		else $error("run mode not reported");
	a_tick_gap: assert property (adc_sample_tick |=> !adc_sample_tick [*8])
		else $error("sample ticks too close");
	a_tick_gated: assert property (adc_sample_tick |->
		$past(unit_clk_en[RCG_U_ADC]))
		else $error("tick while converter unclocked");
endmodule : rcg_top_props
bind rcg_top rcg_top_props #(.NUM_UNITS(NUM_UNITS)) u_props (
	.core_clk(core_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
	.sleep_req(sleep_req), .deep_sleep_req(deep_sleep_req),
	.unit_access(unit_access), .unit_clk_en(unit_clk_en),
	.unit_hold(unit_hold), .unit_fault(unit_fault),
	.adc_sample_tick(adc_sample_tick), .power_mode(power_mode));
`default_nettype wire

// file: sim/rcg_units_model.sv
// stand-in for the gated units: issues accesses, records faults
// assumes the gating block's core clock and reset
`timescale 1ns/1ps
`default_nettype none
module rcg_units_model (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic [2:0] poke,
	input wire logic force_bad,
	input wire logic [2:0] unit_clk_en,
	input wire logic [2:0] unit_fault,
	output var logic [2:0] unit_access,
	output var logic [2:0] fault_seen
);
	// units are touched only once enabled, unless a fault test asks
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			unit_access <= 3'h0;
		end else begin
			unit_access <= poke & (unit_clk_en | {3{force_bad}});
		end
	end
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			fault_seen <= 3'h0;
		end else begin
			fault_seen <= fault_seen | unit_fault;
		end
	end
endmodule : rcg_units_model
`default_nettype wire

// file: sim/testbench.sv
// self-checking bench for the run-mode clock gating block
// assumes rcg_top, its checker and the unit stand-in
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin failures++; \
	$display("wrong value t=%0t got=%h exp=%h", $time, g, e); end end
module testbench
	import rcg_pkg::*;
;
	logic core_clk, rst_n, cyc, stb, we, ack, err, tick, re;
	logic sleep_req, deep_sleep_req, force_bad;
	logic [11:0] adr;
	logic [3:0] sel;
	logic [31:0] wdat, rdat, rq;
	logic [2:0] poke, acc, clk_en, hold, fault, seen, mode;
	logic [1:0] rate;
	int failures, cmp_count;
	rcg_top uut (.core_clk(core_clk), .rst_n(rst_n), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
		.wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err),
		.sleep_req(sleep_req), .deep_sleep_req(deep_sleep_req),
		.unit_access(acc), .unit_clk_en(clk_en), .unit_hold(hold),
		.unit_fault(fault), .converter_sample_rate(rate),
		.adc_sample_tick(tick), .power_mode(mode));
	rcg_units_model u_units (.core_clk(core_clk), .rst_n(rst_n),
		.poke(poke), .force_bad(force_bad), .unit_clk_en(clk_en),
		.unit_fault(fault), .unit_access(acc), .fault_seen(seen));
	task automatic wb(input logic w, input logic [11:0] a,
		input logic [31:0] d, input logic [3:0] s);
		int n;
		n = 0;
		@(posedge core_clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		sel <= s;
		@(posedge core_clk);
		while (ack !== 1'b1 && err !== 1'b1 && n < 16) begin
			@(posedge core_clk);
			n++;
		end
		rq = rdat;
		re = err;
		if (n == 16) failures++;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask : wb
	task automatic step(input int n);
		repeat (n) @(posedge core_clk);
	endtask : step
	task automatic t_reset;
		`CHK(clk_en, 3'h0)
		`CHK(hold, 3'h7)
		wb(0, RCG_OFS_RUN, 0, 4'hF);
		`CHK(rq, 32'h00000040)
		wb(1, RCG_OFS_CAP, 0, 4'hF);
		wb(0, RCG_OFS_CAP, 0, 4'hF);
		`CHK(rq[1:0], 2'h3)
		wb(0, 12'h200, 0, 4'hF);
		`CHK(re, 1'b1)
	endtask : t_reset
	task automatic t_fields;
		// every bit set except the top rate bit: fastest legal code
		wb(1, RCG_OFS_RUN, 32'hFFFFFDFF, 4'hF);
		wb(0, RCG_OFS_RUN, 0, 4'hF);
		`CHK(rq, 32'h00110148)
		`CHK(clk_en, 3'h7)
		`CHK(rate, 2'h1)
		wb(1, RCG_OFS_RUN, 0, 4'h2);
		wb(0, RCG_OFS_RUN, 0, 4'hF);
		`CHK(rq, 32'h00110048)
	endtask : t_fields
	task automatic t_each;
		int bits[3] = '{3, 16, 20};
		for (int i = 0; i < 3; i++) begin
			wb(1, RCG_OFS_RUN, 32'h1 << bits[i], 4'hF);
			step(1);
			`CHK(clk_en, 3'h1 << i)
		end
		wb(1, RCG_OFS_RUN, 0, 4'hF);
		step(1);
		`CHK(hold, 3'h7)
	endtask : t_each
	task automatic t_fault;
		force_bad <= 1'b1;
		poke <= 3'h2;
		step(1);
		poke <= 3'h0;
		step(6);
		`CHK(seen, 3'h2)
		wb(0, RCG_OFS_FLT, 0, 4'hF);
		`CHK(rq[2:0], 3'h2)
		wb(1, RCG_OFS_FLT, 32'h2, 4'h1);
		wb(1, RCG_OFS_RUN, 32'h00010000, 4'hF);
		step(2);
		poke <= 3'h2;
		step(1);
		poke <= 3'h0;
		force_bad <= 1'b0;
		step(6);
		wb(0, RCG_OFS_FLT, 0, 4'hF);
		`CHK(rq[2:0], 3'h0)
	endtask : t_fault
	task automatic wait_tick;
		int n;
		n = 0;
		@(posedge core_clk);
		while (tick !== 1'b1 && n < 300) begin
			@(posedge core_clk);
			n++;
		end
		if (n == 300) failures++;
	endtask : wait_tick
	task automatic t_rate;
		int n;
		// only codes 1 and 0: nothing above the fastest rate
		for (int c = 1; c >= 0; c--) begin
			wb(1, RCG_OFS_RUN, 32'h00010000 | (c << 8), 4'hF);
			wait_tick();
			wait_tick();
			n = 1;
			@(posedge core_clk);
			while (tick !== 1'b1 && n < 300) begin
				@(posedge core_clk);
				n++;
			end
			`CHK(n, c ? RCG_CYC_250K : RCG_CYC_125K)
		end
	endtask : t_rate
	task automatic t_modes;
		wb(1, RCG_OFS_RUN, 32'h00110008, 4'hF);
		wb(1, RCG_OFS_CFG, 32'h1, 4'hF);
		wb(1, RCG_OFS_DSLP, 32'h8, 4'hF);
		sleep_req <= 1'b1;
		step(3);
		`CHK(clk_en, 3'h0)
		`CHK(mode, 3'h2)
		deep_sleep_req <= 1'b1;
		step(3);
		`CHK(clk_en, 3'h1)
		`CHK(mode, 3'h4)
		wb(0, RCG_OFS_EFF, 0, 4'hF);
		`CHK(rq, 32'h00000008)
		deep_sleep_req <= 1'b0;
		wb(1, RCG_OFS_CFG, 32'h0, 4'hF);
		step(2);
		`CHK(clk_en, 3'h7)
		sleep_req <= 1'b0;
	endtask : t_modes
	task automatic close_out;
		$display("checks=%0d failures=%0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : close_out
	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end
	initial begin
		repeat (20000) @(posedge core_clk);
		failures++;
		close_out();
	end
	initial begin
		{rst_n, cyc, stb, we, sleep_req, deep_sleep_req, force_bad} = '0;
		{adr, sel, wdat, poke} = '0;
		failures = 0;
		cmp_count = 0;
		step(4);
		rst_n <= 1'b1;
		step(1);
		t_reset();
		t_fields();
		t_each();
		t_fault();
		t_rate();
		t_modes();
		close_out();
	end
endmodule : testbench
`default_nettype wire
